/* File: core/sdt_core.sv */
/*
  Sequence and status timing of a servo amplifier's discrete control interface.
  Assumes sequence pins and the alarm condition arrive asynchronously; one 50 MHz clock.
*/
// What this block does
// - After reset the block counts about 2.0 s of initialisation and then raises servo control ready.
// - Motion is accepted only once operation ready has been raised in answer to servo-on.
// - Every sequence input change is recognised internally within 2 ms.
// - About 2 ms after deviation clear the deviation is forced to zero and zero deviation rises; host sends no pulses.
// - A control-mode switch completes 2 ms after the selection input change is recognised.
// - An alarm condition drives the alarm output within about 0.5 ms.
// - With free-run stop action (1, 3, 5) the alarm clears about 1.5 ms after alarm reset.
// - With braking stop action (0, 2, 4) the alarm clears about 80 ms after alarm reset.
`timescale 1ns/1ps
module sdt_core
  import sdt_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_CYC,
  parameter int unsigned BRAKE_CYCLES = RESET_BRAKE_CYC,
  parameter int unsigned DET_CYCLES = ALARM_DET_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Sequence input pins
  input wire logic [N_SEQ-1:0] seq_in,
  // Alarm source and setting
  input wire logic alarm_cond,
  input wire logic [STOP_W-1:0] alarm_stop_action_setting,
  // Status outputs
  output logic servo_ctrl_ready,
  output logic operation_ready,
  output logic motion_enable,
  output logic zero_deviation,
  output logic deviation_forced_zero,
  output logic control_mode,
  output logic mode_switching,
  output logic alarm_out,
  output logic [N_SEQ-1:0] seq_recognised
);
  // ==========================================================================
  // Input filters
  // ==========================================================================
  logic [N_SEQ-1:0] seq_lvl;
  genvar gi;
  generate
    for (gi = 0; gi < N_SEQ; gi++) begin : g_in
      sdt_in_filter u_filt (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .pin_in(seq_in[gi]),
        .level_out(seq_lvl[gi])
      );
    end
  endgenerate

  logic [2:0] alm_sync_q;
  logic [2:0] alm_sync_d;

  // ==========================================================================
  // State and counters
  // ==========================================================================
  sdt_state_t st_q, st_d;
  logic [CNT_W-1:0] init_cnt_q, init_cnt_d;
  logic [CNT_W-1:0] clr_cnt_q, clr_cnt_d;
  logic [CNT_W-1:0] mode_cnt_q, mode_cnt_d;
  logic [CNT_W-1:0] det_cnt_q, det_cnt_d;
  logic [CNT_W-1:0] rst_cnt_q, rst_cnt_d;
  logic rst_busy_q, rst_busy_d;
  logic rdy_q, rdy_d, op_q, op_d, mot_q, mot_d;
  logic zd_q, zd_d, mode_q, mode_d, msw_q, msw_d, alm_q, alm_d;
  logic [N_SEQ-1:0] rec_q;
  logic alm_hit;
  logic [CNT_W-1:0] rst_lim;
  logic free_run;

  always_comb begin
    alm_sync_d = {alm_sync_q[1:0], alarm_cond};
    alm_hit = alm_sync_q[1] & alm_sync_q[2];
    free_run = alarm_stop_action_setting[0];
    rst_lim = free_run ? CNT_W'(RESET_FREE_CYC - 1) : CNT_W'(BRAKE_CYCLES - 1);
    st_d = st_q;
    init_cnt_d = init_cnt_q;
    rdy_d = rdy_q;
    op_d = op_q;
    case (st_q)
      ST_INIT: begin
        if (init_cnt_q == CNT_W'(INIT_CYCLES - 1)) begin
          rdy_d = 1'h1;
          st_d = ST_WAIT_ON;
        end else begin
          init_cnt_d = init_cnt_q + CNT_W'(1);
        end
      end
      ST_WAIT_ON: begin
        if (seq_lvl[IN_SERVO_ON] && !alm_q) begin
          op_d = 1'h1;
          st_d = ST_READY;
        end
      end
      ST_READY: begin
        if (!seq_lvl[IN_SERVO_ON] || alm_q) begin
          op_d = 1'h0;
          st_d = ST_WAIT_ON;
        end
      end
      default: begin
        st_d = ST_INIT;
      end
    endcase
    mot_d = op_q & ~alm_q & ~msw_q & ~seq_lvl[IN_DEV_CLEAR];
    // Deviation clear: zero after the clear has been held 2 ms.
    clr_cnt_d = clr_cnt_q;
    zd_d = zd_q;
    if (!seq_lvl[IN_DEV_CLEAR]) begin
      clr_cnt_d = '0;
      zd_d = 1'h0;
    end else if (clr_cnt_q == CNT_W'(CLEAR_CYC - 1)) begin
      zd_d = 1'h1;
    end else begin
      clr_cnt_d = clr_cnt_q + CNT_W'(1);
    end
    // Mode switch completes after 2 ms from the recognised change.
    mode_cnt_d = mode_cnt_q;
    mode_d = mode_q;
    msw_d = msw_q;
    if (seq_lvl[IN_MODE_SEL] != mode_q && !msw_q) begin
      msw_d = 1'h1;
      mode_cnt_d = '0;
    end else if (msw_q) begin
      if (mode_cnt_q == CNT_W'(MODE_CYC - 1)) begin
        mode_d = seq_lvl[IN_MODE_SEL];
        msw_d = 1'h0;
      end else begin
        mode_cnt_d = mode_cnt_q + CNT_W'(1);
      end
    end
    // Alarm detection and reset.
    det_cnt_d = det_cnt_q;
    alm_d = alm_q;
    rst_cnt_d = rst_cnt_q;
    rst_busy_d = rst_busy_q;
    if (!alm_q) begin
      rst_busy_d = 1'h0;
      if (!alm_hit) begin
        det_cnt_d = '0;
      end else if (det_cnt_q == CNT_W'(DET_CYCLES - 1)) begin
        alm_d = 1'h1;
        det_cnt_d = '0;
      end else begin
        det_cnt_d = det_cnt_q + CNT_W'(1);
      end
    end else if (!rst_busy_q) begin
      rst_cnt_d = '0;
      rst_busy_d = seq_lvl[IN_ALARM_RST];
    end else if (rst_cnt_q == rst_lim) begin
      alm_d = 1'h0;
      rst_busy_d = 1'h0;
    end else begin
      rst_cnt_d = rst_cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_INIT;
      alm_sync_q <= 3'h0;
      init_cnt_q <= '0;
      clr_cnt_q <= '0;
      mode_cnt_q <= '0;
      det_cnt_q <= '0;
      rst_cnt_q <= '0;
      rst_busy_q <= 1'h0;
      rdy_q <= 1'h0;
      op_q <= 1'h0;
      mot_q <= 1'h0;
      zd_q <= 1'h0;
      mode_q <= MODE_POSITION;
      msw_q <= 1'h0;
      alm_q <= 1'h0;
      rec_q <= '0;
    end else begin
      st_q <= st_d;
      alm_sync_q <= alm_sync_d;
      init_cnt_q <= init_cnt_d;
      clr_cnt_q <= clr_cnt_d;
      mode_cnt_q <= mode_cnt_d;
      det_cnt_q <= det_cnt_d;
      rst_cnt_q <= rst_cnt_d;
      rst_busy_q <= rst_busy_d;
      rdy_q <= rdy_d;
      op_q <= op_d;
      mot_q <= mot_d;
      zd_q <= zd_d;
      mode_q <= mode_d;
      msw_q <= msw_d;
      alm_q <= alm_d;
      rec_q <= seq_lvl;
    end
  end

  assign servo_ctrl_ready = rdy_q;
  assign operation_ready = op_q;
  assign motion_enable = mot_q;
  assign zero_deviation = zd_q;
  assign deviation_forced_zero = zd_q;
  assign control_mode = mode_q;
  assign mode_switching = msw_q;
  assign alarm_out = alm_q;
  assign seq_recognised = rec_q;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_clear_held;
    seq_lvl[IN_DEV_CLEAR] [*8];
  endsequence
  a_ready_needs_init: assert property (@(posedge clk_sys) disable iff (!resetn)
    op_q |-> rdy_q) else $error("operation ready without servo control ready");
  a_op_needs_servo_on: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(op_q) |-> $past(seq_lvl[IN_SERVO_ON])) else $error("operation ready without servo-on");
  a_motion_gated: assert property (@(posedge clk_sys) disable iff (!resetn)
    mot_q |-> $past(op_q)) else $error("motion enabled before operation ready");
  a_zero_after_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(zd_q) |-> $past(seq_lvl[IN_DEV_CLEAR], 2)) else $error("zero deviation without clear");
  a_clear_zero_drop: assert property (@(posedge clk_sys) disable iff (!resetn)
    !seq_lvl[IN_DEV_CLEAR] |=> !zd_q) else $error("zero deviation held after clear release");
  a_clear_not_early: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(seq_lvl[IN_DEV_CLEAR]) |-> !zd_q ##1 s_clear_held ##0 !zd_q) else $error("zero deviation too early");
  a_mode_settles: assert property (@(posedge clk_sys) disable iff (!resetn)
    $changed(mode_q) |-> $past(msw_q) && $past(mode_cnt_q) == CNT_W'(MODE_CYC - 1))
    else $error("mode changed outside the end of a switch");
  a_alarm_detect: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(alm_q) |-> $past(alm_hit)) else $error("alarm raised without condition");
  a_alarm_reset_time: assert property (@(posedge clk_sys) disable iff (!resetn)
    $fell(alm_q) |-> $past(rst_cnt_q) == $past(rst_lim)) else $error("alarm cleared at wrong time");
endmodule : sdt_core

/* File: core/sdt_in_filter.sv */
/*
  Per-input synchroniser and settle filter for the sequence inputs.
  Assumes asynchronous pin levels; one clock domain.
*/
`timescale 1ns/1ps
module sdt_in_filter
  import sdt_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Pin and filtered level
  input wire logic pin_in,
  output logic level_out
);
  // ==========================================================================
  // Synchroniser and settle counter
  // ==========================================================================
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic lvl_q;
  logic lvl_d;

  always_comb begin
    sync_d = {sync_q[1:0], pin_in};
    cnt_d = cnt_q;
    lvl_d = lvl_q;
    if (sync_q[1] != sync_q[2] || sync_q[2] == lvl_q) begin
      cnt_d = 5'h00;
    end else if (cnt_q == 5'(SEQ_FILT_CYC - 1)) begin
      lvl_d = sync_q[2];
      cnt_d = 5'h00;
    end else begin
      cnt_d = cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync_q <= 3'h0;
      cnt_q <= 5'h00;
      lvl_q <= 1'h0;
    end else begin
      sync_q <= sync_d;
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
    end
  end

  assign level_out = lvl_q;
endmodule : sdt_in_filter

/* File: core/sdt_pkg.sv */
/*
  Package of the servo drive sequence timing block: timing figures, derived cycle counts,
  mode encodings, sequence input slots and the sequencer states.
  Assumes a 50 MHz system clock; all counts except the input filter settle count are derived from CLK_HZ.
*/
package sdt_pkg;
  // ==========================================================================
  // Clock and timing figures
  // ==========================================================================
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned INIT_TIME_MS = 2000;
  localparam int unsigned SEQ_RESP_US = 2000;
  localparam int unsigned CLEAR_TIME_US = 2000;
  localparam int unsigned MODE_TIME_US = 2000;
  localparam int unsigned ALARM_DET_US = 500;
  localparam int unsigned RESET_FREE_US = 1500;
  localparam int unsigned RESET_BRAKE_US = 80000;
  // Cycle counts, longest times rounded down.
  localparam int unsigned CYC_PER_US = CLK_HZ / 1000000;
  localparam int unsigned INIT_CYC = INIT_TIME_MS * 1000 * CYC_PER_US;
  localparam int unsigned CLEAR_CYC = CLEAR_TIME_US * CYC_PER_US;
  localparam int unsigned MODE_CYC = MODE_TIME_US * CYC_PER_US;
  localparam int unsigned ALARM_DET_CYC = ALARM_DET_US * CYC_PER_US;
  localparam int unsigned RESET_FREE_CYC = RESET_FREE_US * CYC_PER_US;
  localparam int unsigned RESET_BRAKE_CYC = RESET_BRAKE_US * CYC_PER_US;
  // Input filter settle count, well under the 2 ms response and the 1 ms hold.
  localparam int unsigned SEQ_FILT_CYC = 16;
  localparam int unsigned CNT_W = 27;
  localparam int unsigned N_SEQ = 8;
  localparam int unsigned STOP_W = 3;
  // ==========================================================================
  // Mode encodings
  // ==========================================================================
  localparam logic MODE_POSITION = 1'h0;
  localparam logic MODE_SPEED = 1'h1;
  // Sequence input slots.
  localparam int unsigned IN_SERVO_ON = 0;
  localparam int unsigned IN_DEV_CLEAR = 1;
  localparam int unsigned IN_MODE_SEL = 2;
  localparam int unsigned IN_ALARM_RST = 3;
  typedef enum logic [2:0] {
    ST_INIT = 3'h1,
    ST_WAIT_ON = 3'h2,
    ST_READY = 3'h4
  } sdt_state_t;
endpackage : sdt_pkg

/* File: tb/sdt_core_tb.sv */
/*
  Self-checking bench of the sequence timing block with a host model.
  Assumes shortened init, alarm detection and braking counts; other counts are the package's.
*/
`timescale 1ns/1ps
module sdt_core_tb;
  import sdt_pkg::*;
  localparam int INIT_SIM = 200;
  localparam int BRAKE_SIM = 300;
  localparam int DET_SIM = 500;
  logic clk_sys = 0, resetn = 0, alarm_cond = 0;
  logic [N_SEQ-1:0] want = '0, seq_in, seq_recognised;
  logic [STOP_W-1:0] stop = '0;
  logic servo_ctrl_ready, operation_ready, motion_enable, zero_deviation, deviation_forced_zero;
  logic control_mode, mode_switching, alarm_out, cmd_allowed;
  logic [6:0] obs, obs_q = '0;
  int chg[7];
  int cyc = 0, n_errors = 0, checked = 0, t, ta;
  logic [31:0] rs = 26788, r;
  always #10 clk_sys = ~clk_sys;
  assign obs = {mode_switching, alarm_out, control_mode, zero_deviation, motion_enable, operation_ready,
                servo_ctrl_ready};
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    obs_q <= obs;
    for (int i = 0; i < 7; i++) if (obs[i] !== obs_q[i]) chg[i] <= cyc;
  end
  sdt_core #(.INIT_CYCLES(INIT_SIM), .BRAKE_CYCLES(BRAKE_SIM), .DET_CYCLES(DET_SIM)) u_sdt_core (
    .clk_sys(clk_sys), .resetn(resetn),
    .seq_in(seq_in), .alarm_cond(alarm_cond), .alarm_stop_action_setting(stop),
    .servo_ctrl_ready(servo_ctrl_ready), .operation_ready(operation_ready), .motion_enable(motion_enable),
    .zero_deviation(zero_deviation), .deviation_forced_zero(deviation_forced_zero),
    .control_mode(control_mode), .mode_switching(mode_switching), .alarm_out(alarm_out),
    .seq_recognised(seq_recognised));
  sdt_host_model u_sdt_host_model (.clk_sys(clk_sys), .resetn(resetn), .want(want),
    .servo_ctrl_ready(servo_ctrl_ready), .seq_in(seq_in), .cmd_allowed(cmd_allowed));
  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic chk(input int idx, input logic val, input int start, input int lo, input int hi);
    int d;
    while (obs[idx] !== val && cyc - start <= hi) @(posedge clk_sys);
    step();
    d = chg[idx] - start;
    cmp(obs[idx], val);
    cmp((d < lo || d > hi) ? d : lo, lo);
  endtask : chk
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask : step
  task automatic end_sim();
    $display("checks=%0d errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    fork begin
      repeat (120000) @(posedge clk_sys);
      n_errors++;
      end_sim();
    end join_none
    repeat (2) step();
    resetn = 1;
    t = cyc;
    want[IN_SERVO_ON] = 1'b1;
    chk(0, 1'b1, t, INIT_SIM - 2, INIT_SIM + 4);
    cmp(operation_ready, 1'b0);
    t = cyc;
    chk(1, 1'b1, t, 17, 27);
    chk(2, 1'b1, t, 17, 29);
    $display("test power_on done");
    r = xs();
    step();
    stop = STOP_W'(2 * (r % 3) + 1);
    want[7:4] = r[7:4];
    want[IN_DEV_CLEAR] = 1'b1;
    want[IN_MODE_SEL] = 1'b1;
    alarm_cond = 1'b1;
    t = cyc;
    repeat (30) step();
    cmp(seq_recognised, {r[7:4], 4'h7});
    chk(6, 1'b1, t, 17, 27);
    cmp(motion_enable, 1'b0);
    cmp(cmd_allowed, 1'b0);
    chk(5, 1'b1, t, DET_SIM, DET_SIM + 8);
    want[IN_ALARM_RST] = 1'b1;
    alarm_cond = 1'b0;
    ta = cyc;
    chk(3, 1'b1, t, CLEAR_CYC + 17, CLEAR_CYC + 27);
    cmp(deviation_forced_zero, 1'b1);
    chk(4, 1'b1, t, MODE_CYC + 17, MODE_CYC + 29);
    chk(5, 1'b0, ta, RESET_FREE_CYC + 17, RESET_FREE_CYC + 29);
    r = xs();
    step();
    want[7:4] = r[7:4];
    want[IN_DEV_CLEAR] = 1'b0;
    want[IN_ALARM_RST] = 1'b0;
    t = cyc;
    chk(3, 1'b0, t, 17, 27);
    cmp(seq_recognised, {r[7:4], 4'h5});
    $display("test clear_mode_alarm done");
    r = xs();
    step();
    stop = STOP_W'(2 * (r % 3));
    alarm_cond = 1'b1;
    t = cyc;
    chk(5, 1'b1, t, DET_SIM, DET_SIM + 8);
    want[IN_ALARM_RST] = 1'b1;
    alarm_cond = 1'b0;
    ta = cyc;
    chk(5, 1'b0, ta, BRAKE_SIM + 17, BRAKE_SIM + 29);
    $display("test brake_reset done");
    end_sim();
  end
endmodule : sdt_core_tb

/* File: tb/sdt_host_model.sv */
/*
  Host controller model that drives the sequence pins of the timing block.
  Assumes the bench gives the wanted pin levels and the block's ready output.
*/
`timescale 1ns/1ps
module sdt_host_model
  import sdt_pkg::*;
#(
  parameter int unsigned QUIET_CYC = CLEAR_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Wanted levels and device status
  input wire logic [N_SEQ-1:0] want,
  input wire logic servo_ctrl_ready,
  // Pins and command permission
  output logic [N_SEQ-1:0] seq_in,
  output logic cmd_allowed
);
  logic [CNT_W-1:0] quiet_q;
  logic [N_SEQ-1:0] pins_d;
  always_comb begin
    pins_d = want;
    pins_d[IN_SERVO_ON] = want[IN_SERVO_ON] & (servo_ctrl_ready | seq_in[IN_SERVO_ON]);
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      seq_in <= '0;
      quiet_q <= '0;
    end else begin
      seq_in <= pins_d;
      if (want[IN_DEV_CLEAR] || seq_in[IN_DEV_CLEAR] || want[IN_MODE_SEL] != seq_in[IN_MODE_SEL]) begin
        quiet_q <= CNT_W'(QUIET_CYC);
      end else if (quiet_q != '0) begin
        quiet_q <= quiet_q - CNT_W'(1);
      end
    end
  end
  assign cmd_allowed = (quiet_q == '0) && !seq_in[IN_DEV_CLEAR];
endmodule : sdt_host_model
